// *** sim/comparator_pair_model.sv ***
// behavioural pair of analog comparators
`timescale 1ns/1ps
module comparator_pair_model #(parameter int LAG_NS = 3) (
   input wire logic [1:0] above_i,
   input wire logic powered_i,
   output logic first_raw_o,
   output logic second_raw_o
);
   // high only when powered and above
   assign #(LAG_NS) first_raw_o = powered_i & above_i[0];
   assign #(LAG_NS) second_raw_o = powered_i & above_i[1];
endmodule // comparator_pair_model

// *** sim/dual_comparator_control_checker.sv ***
// port-level checks of the comparator control block
`timescale 1ns/1ps
module dual_comparator_control_checker (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic first_raw_i,
   input wire logic second_raw_i,
   input wire logic sleep_i,
   input wire logic [4:0] port_a_pin_o,
   input wire logic [2:0] comparator_mode_select_o,
   input wire logic input_switch_select_o,
   input wire logic internal_ref_to_positive_o,
   input wire logic comparators_powered_o,
   input wire logic irq_o,
   input wire logic wake_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   wire [2:0] m = comparator_mode_select_o;
   power_off_a: assert property (m == 3'h7 |=> !comparators_powered_o) else $error("powered in off mode");
   power_on_a: assert property (m != 3'h7 |=> comparators_powered_o) else $error("not powered");
   ref_mode_a: assert property (internal_ref_to_positive_o == (m == 3'h2)) else $error("reference route");
   switch_mode_a: assert property (input_switch_select_o |-> m inside {3'h1, 3'h2}) else $error("switch");
   pin_route_a: assert property (m == 3'h6 |-> port_a_pin_o[4:3] == {second_raw_i, first_raw_i})
      else $error("pin route");
   wake_sleep_a: assert property (wake_o |-> sleep_i) else $error("wake while awake");
   irq_wake_a: assert property (irq_o && sleep_i |-> wake_o) else $error("no wake");
   bus_okay_a: assert property (hreadyout_o && !hresp_o) else $error("bus response");
endmodule // dual_comparator_control_checker

bind dual_comparator_control dual_comparator_control_checker chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .first_raw_i(first_raw_i), .second_raw_i(second_raw_i),
   .sleep_i(sleep_i), .port_a_pin_o(port_a_pin_o), .comparator_mode_select_o(comparator_mode_select_o),
   .input_switch_select_o(input_switch_select_o), .internal_ref_to_positive_o(internal_ref_to_positive_o),
   .comparators_powered_o(comparators_powered_o), .irq_o(irq_o), .wake_o(wake_o));

// *** sim/testbench.sv ***
// self-checking bench of the comparator control block
`timescale 1ns/1ps
module testbench;
   logic clk_i = 1'h0, rst_b_i = 1'h0, hsel = 1'h0, hwrite = 1'h0, sleep = 1'h0;
   logic [1:0] htrans = 2'h0, above = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic hready, hresp, fr, sr, irq, wake, pwr, sw, vref;
   logic [4:0] pin_o, oe, pin_in;
   logic [2:0] mode;
   logic [4:0] ana [8] = '{5'h10, 5'h10, 5'h10, 5'h18, 5'h10, 5'h19, 5'h18, 5'h1f};
   int fail_count = 0, total_checks = 0;
   always #12.5 clk_i = ~clk_i;
   // released pins pulled up
   assign pin_in = (oe & pin_o) | ~oe;
   dual_comparator_control DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .first_raw_i(fr), .second_raw_i(sr),
      .sleep_i(sleep), .port_a_pin_i(pin_in), .port_a_pin_o(pin_o), .port_a_pin_oe_o(oe),
      .comparator_mode_select_o(mode), .input_switch_select_o(sw), .internal_ref_to_positive_o(vref),
      .comparators_powered_o(pwr), .irq_o(irq), .wake_o(wake));
   comparator_pair_model #(.LAG_NS(3)) partner (.above_i(above), .powered_i(pwr), .first_raw_o(fr),
      .second_raw_o(sr));
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic edge_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (hready !== 1'h1 && n < 100);
      if (n >= 100) begin
         fail_count++;
         results();
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk_i);
      hsel <= 1'h1;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= w;
      htrans <= 2'h2;
      edge_ready();
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      edge_ready();
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
      xfer(1'h0, idx, 8'h00);
      chk(what, exp, rd);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_b_i <= 1'h1;
      rdchk(8'h1f, 32'h0, "control");
      rdchk(8'h85, 32'h1f, "direction");
      rdchk(8'h0c, 32'h0, "flags");
      rdchk(8'h8c, 32'h0, "enables");
      rdchk(8'h40, 32'h0, "unmapped");
      chk("powered", 32'h1, 32'(pwr));
      $display("test reset done");
      for (int m = 0; m < 8; m++) begin
         xfer(1'h1, 8'h1f, 8'hc8 | 8'(m));
         @(negedge clk_i);
         chk("switch", 32'((m == 1) || (m == 2)), 32'(sw));
         chk("reference", 32'(m == 2), 32'(vref));
         rdchk(8'h05, 32'(ana[m]), "port_data");
      end
      rdchk(8'h1f, 32'h0f, "control");
      $display("test modes done");
      xfer(1'h1, 8'h1f, 8'h06);
      repeat (400) @(posedge clk_i);
      rdchk(8'h1f, 32'h06, "control");
      xfer(1'h1, 8'h0c, 8'h00);
      xfer(1'h1, 8'h85, 8'h00);
      above <= 2'h1;
      @(negedge clk_i);
      chk("pin_route", 32'h1, 32'(pin_o[4:3]));
      chk("pin_enable", 32'h1f, 32'(oe));
      xfer(1'h1, 8'h85, 8'h08);
      @(negedge clk_i);
      chk("pin_enable", 32'h17, 32'(oe));
      xfer(1'h1, 8'h05, 8'h1f);
      @(negedge clk_i);
      chk("pin_drive", 32'h0f, 32'(pin_o));
      rdchk(8'h1f, 32'h46, "control");
      xfer(1'h1, 8'h0c, 8'h00);
      rdchk(8'h0c, 32'h0, "flags");
      above <= 2'h3;
      repeat (5) @(posedge clk_i);
      rdchk(8'h0c, 32'h40, "flags");
      xfer(1'h1, 8'h0c, 8'h00);
      rdchk(8'h0c, 32'h40, "flags");
      rdchk(8'h1f, 32'hc6, "control");
      chk("which_changed", 32'h2, 32'(rd[7:6] ^ 2'h1));
      xfer(1'h1, 8'h0c, 8'h00);
      rdchk(8'h0c, 32'h0, "flags");
      xfer(1'h1, 8'h0c, 8'h40);
      rdchk(8'h0c, 32'h40, "flags");
      $display("test change flag done");
      xfer(1'h1, 8'h8c, 8'h40);
      xfer(1'h1, 8'h0b, 8'h40);
      @(negedge clk_i);
      chk("irq", 32'h0, 32'(irq));
      xfer(1'h1, 8'h0b, 8'hc0);
      sleep <= 1'h1;
      @(negedge clk_i);
      chk("irq", 32'h1, 32'(irq));
      chk("wake", 32'h1, 32'(wake));
      rdchk(8'h1f, 32'hc6, "control");
      sleep <= 1'h0;
      above <= 2'h0;
      rst_b_i <= 1'h0;
      @(negedge clk_i);
      chk("powered", 32'h0, 32'(pwr));
      chk("pin_enable", 32'h0, 32'(oe));
      @(posedge clk_i);
      rst_b_i <= 1'h1;
      rdchk(8'h1f, 32'h0, "control");
      $display("test interrupt done");
      results();
   end
endmodule // testbench

// *** src/dual_comparator_control.sv ***
// comparator control, status, pin routing and change-detect flag behind an ahb-lite slave
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`include "dual_comparator_control_cfg.svh"
// Operation
// - result bit low when positive input below negative, high when above
// - mode 010 puts internal reference on both positive inputs
// - both result bits readable in control register, writes to them ignored
// - mode 110 drives port pins three and four with raw results
// - direction bits still gate driving of those two pins
// - port data read gives zero on pins set as analog inputs
// - change flag sets when any result differs from latched value
// - flag cleared only by writing zero, writing one sets it
// - irq needs change, peripheral and global enables; flag sets regardless
// - any control register access relatches results; mismatch keeps setting flag
// - change coinciding with a control read still sets flag
// - comparators keep running in sleep, enabled change flag wakes core
// - mode 111 powers both comparators off
// - sleep and wake leave control register unchanged
// - reset returns control register to zero, mode 000 pins zero to three analog
// - comparators held powered down while reset asserted
// - control bit 3 selects alternative negative input pins in modes 001, 010
module dual_comparator_control (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic first_raw_i,
   input wire logic second_raw_i,
   input wire logic sleep_i,
   input wire logic [4:0] port_a_pin_i,
   output logic [4:0] port_a_pin_o,
   output logic [4:0] port_a_pin_oe_o,
   output logic [2:0] comparator_mode_select_o,
   output logic input_switch_select_o,
   output logic internal_ref_to_positive_o,
   output logic comparators_powered_o,
   output logic irq_o,
   output logic wake_o
);

   dual_comparator_control_pkg::state_s state_reg;
   dual_comparator_control_pkg::state_s state_next;
   logic addr_take;
   logic [7:0] addr_index;
   logic [1:0] results;
   logic mismatch;
   logic [3:0] analog_now;
   logic [4:0] port_read;
   logic [7:0] read_value;

   // analog pin mask per mode, pins zero to three
   function automatic logic [3:0] analog_mask(input logic [2:0] mode);
      logic [3:0] m;
      m = 4'h0;
      case (mode)
         3'h0: m = 4'hf;
         3'h1: m = 4'hf;
         3'h2: m = 4'hf;
         3'h3: m = 4'h7;
         3'h4: m = 4'hf;
         3'h5: m = 4'h6;
         3'h6: m = 4'h7;
         default: m = 4'h0;
      endcase
      return m;
   endfunction

   function automatic logic [7:0] word_index(input logic [31:0] addr);
      return addr[9:2];
   endfunction

   assign addr_take = hsel_i & htrans_i[1] & hready_i;
   assign addr_index = word_index(haddr_i);
   assign results = state_reg.sync_second;
   assign mismatch = results != state_reg.latched;
   assign analog_now = analog_mask(state_reg.mode);

   assign port_read = port_a_pin_i & ~{1'b0, analog_now};

   always_comb begin
      read_value = 8'h00;
      if (addr_index == `IDX_COMPARATOR_CONTROL) begin
         read_value[`BIT_SECOND_RESULT] = results[1];
         read_value[`BIT_FIRST_RESULT] = results[0];
         read_value[`BIT_INPUT_SWITCH] = state_reg.input_switch;
         read_value[2:0] = state_reg.mode;
      end else if (addr_index == `IDX_PERIPHERAL_FLAGS) begin
         read_value[`BIT_COMPARATOR_CHANGE_FLAG] = state_reg.change_flag;
      end else if (addr_index == `IDX_PERIPHERAL_ENABLES) begin
         read_value[`BIT_COMPARATOR_CHANGE_ENABLE] = state_reg.change_enable;
      end else if (addr_index == `IDX_INTERRUPT_CONTROL) begin
         read_value[`BIT_GLOBAL_IRQ_ENABLE] = state_reg.global_enable;
         read_value[`BIT_PERIPHERAL_IRQ_ENABLE] = state_reg.periph_enable;
      end else if (addr_index == `IDX_PORT_A_DIRECTION) begin
         read_value[4:0] = state_reg.direction;
      end else if (addr_index == `IDX_PORT_A_DATA) begin
         read_value[4:0] = port_read;
      end else begin
         read_value = 8'h00;
      end
   end

   always_comb begin
      state_next = state_reg;
      state_next.sync_first = {second_raw_i, first_raw_i};
      state_next.sync_second = state_reg.sync_first;
      // powered only once out of reset
      state_next.powered = state_reg.mode != `MODE_OFF;
      if (mismatch) begin
         state_next.change_flag = 1'b1;
      end
      // data phase of a write
      state_next.phase = dual_comparator_control_pkg::bus_idle;
      if (state_reg.phase == dual_comparator_control_pkg::bus_write) begin
         if (state_reg.wr_index == `IDX_COMPARATOR_CONTROL) begin
            state_next.mode = hwdata_i[2:0];
            state_next.input_switch = hwdata_i[`BIT_INPUT_SWITCH];
            state_next.latched = results;
         end else if (state_reg.wr_index == `IDX_PERIPHERAL_FLAGS) begin
            state_next.change_flag = hwdata_i[`BIT_COMPARATOR_CHANGE_FLAG] | mismatch;
         end else if (state_reg.wr_index == `IDX_PERIPHERAL_ENABLES) begin
            state_next.change_enable = hwdata_i[`BIT_COMPARATOR_CHANGE_ENABLE];
         end else if (state_reg.wr_index == `IDX_INTERRUPT_CONTROL) begin
            state_next.global_enable = hwdata_i[`BIT_GLOBAL_IRQ_ENABLE];
            state_next.periph_enable = hwdata_i[`BIT_PERIPHERAL_IRQ_ENABLE];
         end else if (state_reg.wr_index == `IDX_PORT_A_DIRECTION) begin
            state_next.direction = hwdata_i[4:0];
         end else if (state_reg.wr_index == `IDX_PORT_A_DATA) begin
            state_next.port_data = hwdata_i[4:0];
         end
      end
      // address phase
      if (addr_take) begin
         state_next.rdata = 32'h0000_0000;
         if (hwrite_i) begin
            state_next.phase = dual_comparator_control_pkg::bus_write;
            state_next.wr_index = addr_index;
         end else begin
            state_next.rdata = {24'h00_0000, read_value};
            if (addr_index == `IDX_COMPARATOR_CONTROL) begin
               // change in this cycle still sets the flag, then is latched
               state_next.latched = results;
            end
         end
      end
      // sleep has no effect on stored settings
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg.phase <= dual_comparator_control_pkg::bus_idle;
         state_reg.wr_index <= 8'h00;
         state_reg.mode <= `RST_COMPARATOR_MODE;
         state_reg.input_switch <= 1'b0;
         state_reg.change_flag <= 1'b0;
         state_reg.change_enable <= 1'b0;
         state_reg.global_enable <= 1'b0;
         state_reg.periph_enable <= 1'b0;
         state_reg.direction <= `RST_PORT_A_DIRECTION;
         state_reg.port_data <= `RST_PORT_A_DATA;
         state_reg.latched <= 2'h0;
         state_reg.sync_first <= 2'h0;
         state_reg.sync_second <= 2'h0;
         state_reg.rdata <= 32'h0000_0000;
         state_reg.powered <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign hrdata_o = state_reg.rdata;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   always_comb begin
      port_a_pin_o = state_reg.port_data;
      if (state_reg.mode == `MODE_PIN_OUTPUTS) begin
         port_a_pin_o[3] = first_raw_i;
         port_a_pin_o[4] = second_raw_i;
      end
   end

   assign port_a_pin_oe_o = ~state_reg.direction;

   assign comparator_mode_select_o = state_reg.mode;
   assign input_switch_select_o = state_reg.input_switch &
      ((state_reg.mode == `MODE_SWITCHED_NEG) | (state_reg.mode == `MODE_INTERNAL_REF));
   assign internal_ref_to_positive_o = state_reg.mode == `MODE_INTERNAL_REF;
   assign comparators_powered_o = state_reg.powered;

   assign irq_o = state_reg.change_flag & state_reg.change_enable &
      state_reg.periph_enable & state_reg.global_enable;
   assign wake_o = sleep_i & state_reg.change_flag & state_reg.change_enable;

endmodule // dual_comparator_control

// *** src/dual_comparator_control_cfg.svh ***
// offsets, field positions, reset values and timing counts of the comparator control block
`ifndef DUAL_COMPARATOR_CONTROL_CFG_SVH
`define DUAL_COMPARATOR_CONTROL_CFG_SVH

// register indices, byte address is four times the index
`define IDX_PORT_A_DATA 8'h05
`define IDX_INTERRUPT_CONTROL 8'h0b
`define IDX_PERIPHERAL_FLAGS 8'h0c
`define IDX_COMPARATOR_CONTROL 8'h1f
`define IDX_PORT_A_DIRECTION 8'h85
`define IDX_PERIPHERAL_ENABLES 8'h8c

// field positions
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_PERIPHERAL_IRQ_ENABLE 6
`define BIT_COMPARATOR_CHANGE_FLAG 6
`define BIT_COMPARATOR_CHANGE_ENABLE 6
`define BIT_SECOND_RESULT 7
`define BIT_FIRST_RESULT 6
`define BIT_INPUT_SWITCH 3
`define POS_MODE_LSB 0
`define PORT_A_WIDTH 5

// reset values
`define RST_COMPARATOR_MODE 3'h0
`define RST_PORT_A_DIRECTION 5'h1f
`define RST_PORT_A_DATA 5'h00

// mode codes
`define MODE_RESET 3'h0
`define MODE_SWITCHED_NEG 3'h1
`define MODE_INTERNAL_REF 3'h2
`define MODE_PIN_OUTPUTS 3'h6
`define MODE_OFF 3'h7

// time for mode change to settle before software reads, for reference
`define MODE_SETTLE_NS 10000
`define MODE_SETTLE_CYCLES ((`MODE_SETTLE_NS + 24) / 25)

`endif

// *** src/dual_comparator_control_pkg.sv ***
// types of the comparator control block
package dual_comparator_control_pkg;

   typedef logic [2:0] mode_t;

   typedef enum logic [1:0] {
      bus_idle = 2'b01,
      bus_write = 2'b10
   } bus_phase_e;

   typedef struct packed {
      bus_phase_e phase;
      logic [7:0] wr_index;
      mode_t mode;
      logic input_switch;
      logic change_flag;
      logic change_enable;
      logic global_enable;
      logic periph_enable;
      logic [4:0] direction;
      logic [4:0] port_data;
      logic [1:0] latched;
      logic [1:0] sync_first;
      logic [1:0] sync_second;
      logic [31:0] rdata;
      logic powered;
   } state_s;

endpackage
